// ===== src/srg_pkg.sv
package srg_pkg;

  // ---------------------------------------------------------------
  // timeout defaults, in clock cycles of CLK (100 MHz)
  // ---------------------------------------------------------------
  localparam int unsigned SRG_SHORT_TIMEOUT_CYCLES = 1000;
  localparam int unsigned SRG_LONG_TIMEOUT_CYCLES  = 15000;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic SRG_RST_ACTIVE_INIT = 1'b1;  // reset asserted at power-up
  localparam logic SRG_MR_SYNC_INIT    = 1'b1;  // manual reset idle (high)
  localparam logic SRG_TS_SYNC_INIT    = 1'b0;  // short option selected

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRG_ASSERT   = 2'b00,  // a cause is present
    SRG_HOLD     = 2'b01,  // causes gone, timeout running
    SRG_RELEASED = 2'b10   // reset released
  } srg_state_t;

endpackage

// ===== src/srg_top.sv
`timescale 1ns/1ps

// What this block does
// - Assert reset at once on low supply.
// - After supply recovers, hold full timeout.
// - Low manual_reset_n asserts reset.
// - Hold while manual low, then one timeout.
// - Timeout runs only with no cause; restarts.
// - timeout_select low short, high long.
// - Active-high output mirrors the same behaviour.
module srg_top
#(
  parameter int unsigned SHORT_TIMEOUT_CYCLES =
    srg_pkg::SRG_SHORT_TIMEOUT_CYCLES,
  parameter int unsigned LONG_TIMEOUT_CYCLES  =
    srg_pkg::SRG_LONG_TIMEOUT_CYCLES
)
(
  input  wire logic CLK,
  input  wire logic RESETN,
  input  wire logic SUPPLY_LOW,
  input  wire logic MANUAL_RESET_N,
  input  wire logic TIMEOUT_SELECT,
  output logic      RESET_OUT_N,
  output logic      RESET_OUT,
  output logic      RESET_OD_OE
);
  import srg_pkg::*;

  localparam int CW = $clog2(LONG_TIMEOUT_CYCLES + 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // zero-length timeouts cannot be counted
  if (SHORT_TIMEOUT_CYCLES < 1 || LONG_TIMEOUT_CYCLES < 1)
  begin : g_bad_timeout
    $error("timeout lengths must be at least one cycle");
  end
  // counter is sized by the long option
  if (SHORT_TIMEOUT_CYCLES > LONG_TIMEOUT_CYCLES)
  begin : g_bad_order
    $error("short timeout must not exceed long timeout");
  end

  localparam logic [CW-1:0] SHORT_LIM = CW'(SHORT_TIMEOUT_CYCLES);
  localparam logic [CW-1:0] LONG_LIM  = CW'(LONG_TIMEOUT_CYCLES);
  localparam logic [CW-1:0] ONE_CW    = CW'(1);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              mr_s1_r;
  logic              mr_s2_r;
  logic              ts_s1_r;
  logic              ts_s2_r;
  logic              cause;
  srg_state_t        state_r;
  srg_state_t        state_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic [CW-1:0]     lim_r;
  logic [CW-1:0]     lim_nxt;
  logic              rst_act_nxt;
  logic              rst_n_r;
  logic              rst_hi_r;
  logic              rst_oe_r;
  logic [CW:0]       calm_r;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // two-stage sync for manual reset; first stage feeds only the second
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      mr_s1_r <= SRG_MR_SYNC_INIT;
      mr_s2_r <= SRG_MR_SYNC_INIT;
    end
    else
    begin
      mr_s1_r <= MANUAL_RESET_N;
      mr_s2_r <= mr_s1_r;
    end
  end

  // two-stage sync for the timeout select strap
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      ts_s1_r <= SRG_TS_SYNC_INIT;
      ts_s2_r <= SRG_TS_SYNC_INIT;
    end
    else
    begin
      ts_s1_r <= TIMEOUT_SELECT;
      ts_s2_r <= ts_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // reset causes
  // ---------------------------------------------------------------
  // supply monitor result is already synchronous, so it acts at once
  assign cause = SUPPLY_LOW | ~mr_s2_r;

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  // any cause forces assert; timeout starts only when all are gone
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    lim_nxt   = lim_r;
    unique case (state_r)
      SRG_ASSERT:
      begin
        if (!cause)
        begin
          state_nxt = SRG_HOLD;
          cnt_nxt   = '0;
          lim_nxt   = ts_s2_r ? LONG_LIM : SHORT_LIM;
        end
      end
      SRG_HOLD:
      begin
        if (cause)
          state_nxt = SRG_ASSERT;
        else if (cnt_r == lim_r - ONE_CW)
          state_nxt = SRG_RELEASED;
        else
          cnt_nxt = cnt_r + ONE_CW;
      end
      SRG_RELEASED:
      begin
        if (cause)
          state_nxt = SRG_ASSERT;
      end
      default:
      begin
        state_nxt = SRG_ASSERT;  // illegal code falls back to reset
      end
    endcase
  end

  // reset stays asserted in every state but released
  assign rst_act_nxt = (state_nxt != SRG_RELEASED);

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  // state, starting with reset asserted
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      state_r <= SRG_ASSERT;
    else
      state_r <= state_nxt;
  end

  // timeout counter and the limit captured at timeout start
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      cnt_r <= '0;
      lim_r <= SHORT_LIM;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      lim_r <= lim_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output drivers
  // ---------------------------------------------------------------
  // both polarities and the open-drain enable share one next value
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      rst_n_r  <= ~SRG_RST_ACTIVE_INIT;
      rst_hi_r <= SRG_RST_ACTIVE_INIT;
      rst_oe_r <= SRG_RST_ACTIVE_INIT;
    end
    else
    begin
      rst_n_r  <= ~rst_act_nxt;
      rst_hi_r <= rst_act_nxt;
      rst_oe_r <= rst_act_nxt;   // pull low while asserted
    end
  end

  assign RESET_OUT_N = rst_n_r;
  assign RESET_OUT   = rst_hi_r;
  assign RESET_OD_OE = rst_oe_r;

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  // consecutive cycles without any cause, saturating
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      calm_r <= '0;
    else if (cause)
      calm_r <= '0;
    else if (calm_r != {(CW+1){1'b1}})
      calm_r <= calm_r + (CW+1)'(1);
  end

  sequence s_cause_gone;
    state_r == SRG_ASSERT && !cause;
  endsequence

  sequence s_hold_entered;
    state_r == SRG_HOLD && cnt_r == '0;
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_supply_assert: assert property (
    @(posedge CLK) disable iff (!RESETN)
    SUPPLY_LOW |=> RESET_OUT && !RESET_OUT_N)
  else $error("reset not asserted after supply low");

  a_manual_assert: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !MANUAL_RESET_N |-> ##3 RESET_OUT)
  else $error("reset not asserted three cycles after manual low");

  a_cause_hold: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cause |=> RESET_OUT)
  else $error("reset released while a cause is present");

  a_enter_hold: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_cause_gone |=> s_hold_entered)
  else $error("timeout did not start when causes cleared");

  a_restart_hold: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (state_r == SRG_HOLD && cause) |=> state_r == SRG_ASSERT && RESET_OUT)
  else $error("timeout not abandoned on a new cause");

  a_full_timeout: assert property (
    @(posedge CLK) disable iff (!RESETN)
    $fell(RESET_OUT) |-> calm_r == {1'b0, lim_r} + (CW+1)'(1))
  else $error("reset released before a full quiet timeout");

  a_no_early_rel: assert property (
    @(posedge CLK) disable iff (!RESETN)
    $fell(RESET_OUT) |-> $past(state_r) == SRG_HOLD &&
      $past(cnt_r) == $past(lim_r) - ONE_CW)
  else $error("reset released outside the end of the timeout");

  a_short_pick: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (s_cause_gone and !ts_s2_r) |=> lim_r == SHORT_LIM)
  else $error("short timeout not chosen with select low");

  a_long_pick: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (s_cause_gone and ts_s2_r) |=> lim_r == LONG_LIM)
  else $error("long timeout not chosen with select high");

  a_polarity_pair: assert property (
    @(posedge CLK) disable iff (!RESETN)
    RESET_OUT == !RESET_OUT_N && RESET_OD_OE == RESET_OUT)
  else $error("output polarities disagree");

endmodule

// ===== testbench/srg_cpu_model.sv
`timescale 1ns/1ps

// processor side: open-drain reset line with pullup
module srg_cpu_model
(
  input  wire logic reset_od_oe,
  output logic      held
);
  logic od_wire;

  // pullup wins unless the device sinks the line
  assign od_wire = reset_od_oe ? 1'b0 : 1'b1;
  // processor is held while the line is low
  assign held = ~od_wire;
endmodule

// ===== testbench/tb_supervisory_reset_generator.sv
`timescale 1ns/1ps

module tb_supervisory_reset_generator;
  import srg_pkg::*;

  localparam int unsigned S = 5;
  localparam int unsigned L = 12;
  localparam logic [3:0]  ASSERTED = 4'hb;
  localparam logic [3:0]  RELEASED = 4'h4;

  typedef struct {
    logic        sl;
    logic        mr_low;
    logic        ts;
    int unsigned hold;
  } srg_case_t;

  logic       clk;
  logic       resetn;
  logic       supply_low;
  logic       manual_reset_n;
  logic       timeout_select;
  logic       reset_out_n;
  logic       reset_out;
  logic       reset_od_oe;
  logic       held;
  wire  [3:0] obs = {reset_out, reset_out_n, reset_od_oe, held};
  int         mismatches = 0;
  int         cmp_count = 0;

  // cause, select, cycles still held after clearing; release follows one cycle later
  srg_case_t rows [6] = '{
    '{1'b1, 1'b0, 1'b0, S}, '{1'b1, 1'b0, 1'b1, L},
    '{1'b0, 1'b1, 1'b0, S + 2}, '{1'b0, 1'b1, 1'b1, L + 2},
    '{1'b1, 1'b1, 1'b0, S + 2}, '{1'b1, 1'b1, 1'b1, L + 2}};

  srg_top #(.SHORT_TIMEOUT_CYCLES(S), .LONG_TIMEOUT_CYCLES(L)) srg_top_inst
  (
    .CLK            (clk),
    .RESETN         (resetn),
    .SUPPLY_LOW     (supply_low),
    .MANUAL_RESET_N (manual_reset_n),
    .TIMEOUT_SELECT (timeout_select),
    .RESET_OUT_N    (reset_out_n),
    .RESET_OUT      (reset_out),
    .RESET_OD_OE    (reset_od_oe)
  );

  srg_cpu_model srg_cpu_model_inst
  (
    .reset_od_oe (reset_od_oe),
    .held        (held)
  );

  // ---------------------------------------------------------------
  // clock and helpers
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // compare and count
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t outputs %b expected %b", $time, seen, exp);
    end
  endtask

  // causes cleared just now: held n cycles, then released
  task automatic release_after(input int unsigned n);
    repeat (n) @(negedge clk);
    chk(obs, ASSERTED);
    @(negedge clk);
    chk(obs, RELEASED);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    supply_low = 1'b0;
    manual_reset_n = 1'b1;
    timeout_select = 1'b0;
    repeat (2) @(negedge clk);
    chk(obs, ASSERTED);
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    release_after(S);
    // table of causes and options
    foreach (rows[i])
    begin
      supply_low = rows[i].sl;
      manual_reset_n = ~rows[i].mr_low;
      timeout_select = rows[i].ts;
      repeat (2)
      begin
        @(negedge clk);
        chk(obs, rows[i].sl ? ASSERTED : RELEASED);
      end
      @(negedge clk);
      chk(obs, ASSERTED);
      supply_low = 1'b0;
      manual_reset_n = 1'b1;
      release_after(rows[i].hold);
      repeat (3) @(negedge clk);
    end
    timeout_select = 1'b0;
    repeat (3) @(negedge clk);
    // supply dips again mid-timeout, full count restarts
    supply_low = 1'b1;
    repeat (2) @(negedge clk);
    supply_low = 1'b0;
    repeat (3) @(negedge clk);
    chk(obs, ASSERTED);
    supply_low = 1'b1;
    @(negedge clk);
    supply_low = 1'b0;
    repeat (2) @(negedge clk);
    // a count kept from the first clear would have released by now
    chk(obs, ASSERTED);
    // manual press in mid-timeout
    manual_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    manual_reset_n = 1'b1;
    release_after(S + 2);
    // select flipped mid-timeout is ignored
    supply_low = 1'b1;
    repeat (2) @(negedge clk);
    supply_low = 1'b0;
    repeat (2) @(negedge clk);
    timeout_select = 1'b1;
    release_after(S - 2);
    timeout_select = 1'b0;
    repeat (4) @(negedge clk);
    // second reset in mid-run
    resetn = 1'b0;
    @(negedge clk);
    chk(obs, ASSERTED);
    resetn = 1'b1;
    release_after(S);
    final_report();
  end

  // hang guard, far beyond the roughly 160 cycles needed
  initial
  begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule
